// [include/link_monitor_pkg.sv]
// Shared constants for the serial link error and status monitor
`default_nettype none
package link_monitor_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CHK_MODE_ADDR = 12'h300;
  localparam logic [11:0] RX_PARAM_BASE = 12'h400;
  localparam logic [11:0] CFG_PARAM_BASE = 12'h450;
  localparam logic [11:0] COUNT_VIEW_ADDR = 12'h46B;
  localparam logic [11:0] ERR_CTRL_BASE = 12'h46D;
  localparam logic [11:0] CODE_GROUP_SYNC_ADDR = 12'h470;
  localparam logic [11:0] FRAME_SYNC_ADDR = 12'h471;
  localparam logic [11:0] CHECKSUM_GOOD_ADDR = 12'h472;
  localparam logic [11:0] LANE_ALIGN_ADDR = 12'h473;
  localparam logic [11:0] LINK_CTRL_ADDR = 12'h477;
  localparam logic [11:0] IRQ_ENABLE_ADDR = 12'h47A;
  localparam logic [11:0] RESYNC_MASK_ADDR = 12'h47B;
  localparam logic [11:0] THRESHOLD_ADDR = 12'h47C;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CHK_MODE_BIT = 6;
  localparam int MASK_EN_BIT = 3;
  localparam int ILAS_TEST_BIT = 7;
  localparam int FLAG_IRQ_CLEAR_BIT = 7;
  localparam int ERR_IRQ_CLEAR_BIT = 7;
  localparam int ERR_DISABLE_BIT = 6;
  localparam int ERR_RESET_BIT = 5;
  localparam int ERR_IRQ_LSB = 5;
  localparam int MISMATCH_EN_BIT = 3;
  localparam int MISMATCH_ST_BIT = 4;
  localparam int RESYNC_MASK_LSB = 5;
  localparam int VIEW_LANE_LSB = 4;
  localparam int FRAME_OCTETS_BYTE = 4;
  // ----------------------------------------------------------------
  // Sizes, counts and reset values
  // ----------------------------------------------------------------
  localparam int ERR_TYPES = 3;
  localparam int PARAM_BYTES = 14;
  localparam int PACKED_SUM_BYTES = 13;
  localparam int DISP_REINIT_COUNT = 4;
  localparam int RESYNC_FRAMES = 5;
  localparam int RESYNC_OCTETS = 9;
  localparam logic MISMATCH_EN_RESET = 1'b1;
  localparam logic [7:0] THRESHOLD_RESET = 8'hFF;

  // Field-wise checksum over the link parameter bytes, lane id substituted
  function automatic logic [7:0] field_checksum(input logic [PARAM_BYTES*8-1:0] p, input logic [4:0] lid);
    logic [7:0] s;
    s = p[7:0] + {4'h0, p[11:8]} + {3'h0, lid} + {7'h00, p[31]} + {3'h0, p[28:24]};
    s = s + p[39:32] + {3'h0, p[44:40]} + p[55:48] + {3'h0, p[60:56]};
    s = s + {5'h00, p[71:69]} + {3'h0, p[68:64]} + {5'h00, p[79:77]} + {3'h0, p[76:72]};
    s = s + {7'h00, p[87]};
    return s;
  endfunction
endpackage
`default_nettype wire

// [core/lane_error_counter.sv]
// Per-lane, per-type error counter with optional saturation at threshold
`default_nettype none
module lane_error_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Control
  input wire logic error_i,
  input wire logic clear_i,
  input wire logic disable_i,
  input wire logic saturate_i,
  input wire logic [WIDTH-1:0] threshold_i,
  // Result
  output logic [WIDTH-1:0] count_o,
  output logic reached_o
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } state_type;

  state_type state_q;
  state_type state_d;

  generate
    if (WIDTH < 2) begin : g_bad_width
      $error("lane_error_counter: WIDTH must be at least 2");
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    if (clear_i) begin
      state_d.count = '0;
    end else if (error_i && !disable_i) begin
      if (saturate_i && (state_q.count >= threshold_i || &state_q.count)) begin
        state_d.count = state_q.count;
      end else begin
        state_d.count = state_q.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign count_o = state_q.count;
  // A zero threshold never counts as reached, so writing zero to the threshold keeps the event quiet
  assign reached_o = (threshold_i != '0) && (state_q.count >= threshold_i);
endmodule
`default_nettype wire

// [core/serial_link_error_status_monitor.sv]
// Receive-side link error counting, resync request and status flag block
`default_nettype none
module serial_link_error_status_monitor #(
  parameter int LANES = 4,
  parameter int COUNT_WIDTH = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // Per-lane decoder error strobes
  input wire logic [LANES-1:0] disparity_error_i,
  input wire logic [LANES-1:0] not_in_table_error_i,
  input wire logic [LANES-1:0] unexpected_control_error_i,
  // Per-lane link establishment status
  input wire logic [LANES-1:0] code_group_sync_i,
  input wire logic [LANES-1:0] frame_sync_i,
  input wire logic [LANES-1:0] lane_alignment_i,
  // Received link parameters
  input wire logic params_valid_i,
  input wire logic [link_monitor_pkg::PARAM_BYTES*8-1:0] rx_params_i,
  input wire logic [LANES*8-1:0] rx_checksum_i,
  input wire logic [LANES*5-1:0] rx_lane_id_i,
  // Link and system outputs
  output logic sync_request_output_n_o,
  output logic irq_o
);
  localparam int NB = link_monitor_pkg::PARAM_BYTES;
  localparam int NT = link_monitor_pkg::ERR_TYPES;

  generate
    if (LANES < 1 || LANES > 8) begin : g_bad_lanes
      $error("serial_link_error_status_monitor: LANES must be 1 to 8");
    end
    if (COUNT_WIDTH != 8) begin : g_bad_width
      $error("serial_link_error_status_monitor: COUNT_WIDTH must be 8");
    end
  endgenerate

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] irq_enable;
    logic [2:0] resync_mask;
    logic mismatch_enable;
    logic mismatch_status;
    logic mask_enable;
    logic ilas_test;
    logic checksum_mode;
    logic [7:0] threshold;
    logic [NB-1:0][7:0] cfg_params;
    logic [2:0] view_lane;
    logic [1:0] view_type;
    logic [NT-1:0][LANES-1:0] count_disable;
    logic [NT-1:0][LANES-1:0] error_status;
    logic [NT-1:0][LANES-1:0] reached_prev;
    logic [LANES-1:0] cgs_flags;
    logic [LANES-1:0] frame_flags;
    logic [LANES-1:0] checksum_flags;
    logic [LANES-1:0] align_flags;
    logic [3:0] fail_status;
    logic [LANES-1:0][2:0] disparity_run;
    logic [10:0] hold_count;
    logic [7:0] rdata;
    logic irq;
    logic sync_n;
  } state_type;

  state_type state_q;
  state_type state_d;

  // ----------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------
  logic [NT-1:0][LANES-1:0] err_strobe;
  logic [NT-1:0][LANES-1:0] cnt_clear;
  logic [NT-1:0][LANES-1:0] reached;
  logic [NT-1:0][LANES-1:0][COUNT_WIDTH-1:0] count;
  logic reinit;

  assign err_strobe[0] = disparity_error_i;
  assign err_strobe[1] = not_in_table_error_i;
  assign err_strobe[2] = unexpected_control_error_i;

  genvar gt, gl;
  generate
    for (gt = 0; gt < NT; gt++) begin : g_type
      for (gl = 0; gl < LANES; gl++) begin : g_lane
        lane_error_counter #(
          .WIDTH(COUNT_WIDTH)
        ) u_counter (
          .clock_i(clock_i),
          .reset_n_i(reset_n_i),
          .error_i(err_strobe[gt][gl]),
          .clear_i(cnt_clear[gt][gl]),
          .disable_i(state_q.count_disable[gt][gl]),
          // Counters of a resync-enabled type wrap so a repeat trigger stays possible
          .saturate_i(!(state_q.mask_enable && state_q.resync_mask[NT-1-gt])),
          .threshold_i(state_q.threshold),
          .count_o(count[gt][gl]),
          .reached_o(reached[gt][gl])
        );
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checksums and parameter comparison
  // ----------------------------------------------------------------
  logic [LANES-1:0] checksum_match;
  logic params_differ;

  always_comb begin
    logic [7:0] packed_sum;
    logic [7:0] expected;
    packed_sum = '0;
    expected = '0;
    for (int b = 0; b < link_monitor_pkg::PACKED_SUM_BYTES; b++) begin
      packed_sum = packed_sum + rx_params_i[b*8 +: 8];
    end
    for (int l = 0; l < LANES; l++) begin
      if (state_q.checksum_mode) begin
        expected = packed_sum + {3'h0, rx_lane_id_i[l*5 +: 5]};
      end else begin
        expected = link_monitor_pkg::field_checksum(rx_params_i, rx_lane_id_i[l*5 +: 5]);
      end
      checksum_match[l] = (expected == rx_checksum_i[l*8 +: 8]);
    end
  end

  assign params_differ = (state_q.cfg_params != rx_params_i);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [11:0] a;
    logic [7:0] w;
    logic wr;
    logic disp_reinit;
    logic thr_reinit;
    logic [NT-1:0][LANES-1:0] irq_clear;
    logic [3:0] fail_set;
    logic [3:0] fail_clear;
    logic [7:0] event_status;
    logic [10:0] frame_octets;
    int t;
    int sel;
    a = reg_addr_i;
    w = reg_wdata_i;
    wr = reg_write_i;
    disp_reinit = 1'b0;
    thr_reinit = 1'b0;
    irq_clear = '0;
    fail_set = '0;
    fail_clear = '0;
    event_status = '0;
    frame_octets = '0;
    t = 0;
    sel = 0;
    cnt_clear = '0;
    state_d = state_q;

    // Register writes
    if (wr) begin
      case (a)
        link_monitor_pkg::CHK_MODE_ADDR: state_d.checksum_mode = w[link_monitor_pkg::CHK_MODE_BIT];
        link_monitor_pkg::COUNT_VIEW_ADDR: begin
          state_d.view_lane = w[link_monitor_pkg::VIEW_LANE_LSB +: 3];
          state_d.view_type = w[1:0];
        end
        link_monitor_pkg::LINK_CTRL_ADDR: begin
          state_d.mask_enable = w[link_monitor_pkg::MASK_EN_BIT];
          state_d.ilas_test = w[link_monitor_pkg::ILAS_TEST_BIT];
        end
        link_monitor_pkg::IRQ_ENABLE_ADDR: state_d.irq_enable = w & 8'hEF;
        link_monitor_pkg::RESYNC_MASK_ADDR: begin
          state_d.resync_mask = w[link_monitor_pkg::RESYNC_MASK_LSB +: 3];
          state_d.mismatch_enable = w[link_monitor_pkg::MISMATCH_EN_BIT];
        end
        link_monitor_pkg::THRESHOLD_ADDR: state_d.threshold = w;
        default: begin
        end
      endcase
      if (a >= link_monitor_pkg::CFG_PARAM_BASE && a < link_monitor_pkg::CFG_PARAM_BASE + 12'(NB)) begin
        state_d.cfg_params[a - link_monitor_pkg::CFG_PARAM_BASE] = w;
      end
      if (a >= link_monitor_pkg::ERR_CTRL_BASE && a < link_monitor_pkg::ERR_CTRL_BASE + 12'(NT)) begin
        t = int'(a - link_monitor_pkg::ERR_CTRL_BASE);
        sel = int'(w[2:0]);
        if (sel < LANES) begin
          irq_clear[t][sel] = w[link_monitor_pkg::ERR_IRQ_CLEAR_BIT];
          state_d.count_disable[t][sel] = w[link_monitor_pkg::ERR_DISABLE_BIT];
          cnt_clear[t][sel] = w[link_monitor_pkg::ERR_RESET_BIT];
        end
      end
      for (int f = 0; f < 4; f++) begin
        if (a == link_monitor_pkg::CODE_GROUP_SYNC_ADDR + 12'(f)) begin
          fail_clear[f] = w[link_monitor_pkg::FLAG_IRQ_CLEAR_BIT];
        end
      end
    end

    // Per-lane stage flags
    state_d.cgs_flags = code_group_sync_i;
    state_d.frame_flags = frame_sync_i;
    state_d.align_flags = lane_alignment_i;
    if (params_valid_i) begin
      state_d.checksum_flags = checksum_match;
    end
    // A flag falling on any lane, or a bad checksum, is a stage failure
    fail_set[0] = |(state_q.cgs_flags & ~code_group_sync_i);
    fail_set[1] = |(state_q.frame_flags & ~frame_sync_i);
    fail_set[2] = params_valid_i && !(&checksum_match);
    fail_set[3] = |(state_q.align_flags & ~lane_alignment_i);
    state_d.fail_status = (state_q.fail_status & ~fail_clear) | fail_set;

    // Error type events and threshold reinit
    state_d.reached_prev = reached;
    for (int ty = 0; ty < NT; ty++) begin
      state_d.error_status[ty] = (state_q.error_status[ty] & ~irq_clear[ty]) | reached[ty];
      if (state_q.mask_enable && state_q.resync_mask[NT-1-ty] && |(reached[ty] & ~state_q.reached_prev[ty])) begin
        thr_reinit = 1'b1;
      end
    end

    // Invalid disparity run per lane
    for (int l = 0; l < LANES; l++) begin
      if (disparity_error_i[l]) begin
        if (state_q.disparity_run[l] == 3'(link_monitor_pkg::DISP_REINIT_COUNT - 1)) begin
          disp_reinit = 1'b1;
        end
        state_d.disparity_run[l] = state_q.disparity_run[l] + 3'h1;
      end
    end

    // Reinitialisation clears every counter but not the sticky status
    reinit = disp_reinit || thr_reinit;
    if (reinit) begin
      cnt_clear = '1;
      state_d.disparity_run = '0;
      state_d.reached_prev = '0;
      frame_octets = {3'h0, state_q.cfg_params[link_monitor_pkg::FRAME_OCTETS_BYTE]} + 11'h001;
      state_d.hold_count = 11'(link_monitor_pkg::RESYNC_FRAMES) * frame_octets
        + 11'(link_monitor_pkg::RESYNC_OCTETS);
    end else if (state_q.hold_count != '0) begin
      state_d.hold_count = state_q.hold_count - 11'h001;
    end
    state_d.sync_n = !(reinit || state_q.hold_count > 11'h001);

    // Mismatch flag, set wins over clear
    if (wr && a == link_monitor_pkg::RESYNC_MASK_ADDR && w[link_monitor_pkg::MISMATCH_ST_BIT]) begin
      state_d.mismatch_status = 1'b0;
    end
    if (params_differ) begin
      state_d.mismatch_status = 1'b1;
    end

    // Interrupt output
    for (int ty = 0; ty < NT; ty++) begin
      event_status[link_monitor_pkg::ERR_IRQ_LSB + NT - 1 - ty] = |state_q.error_status[ty];
    end
    event_status[3:0] = state_q.fail_status;
    state_d.irq = |(event_status & state_q.irq_enable)
      || (state_q.mismatch_enable && state_q.mismatch_status);

    // Register reads, answered on the next edge
    if (reg_read_i) begin
      state_d.rdata = 8'h00;
      case (a)
        link_monitor_pkg::CHK_MODE_ADDR: state_d.rdata[link_monitor_pkg::CHK_MODE_BIT] = state_q.checksum_mode;
        link_monitor_pkg::COUNT_VIEW_ADDR: begin
          if (state_q.view_type < 2'(NT) && int'(state_q.view_lane) < LANES) begin
            state_d.rdata = count[state_q.view_type][state_q.view_lane];
          end
        end
        link_monitor_pkg::CODE_GROUP_SYNC_ADDR: state_d.rdata = 8'(state_q.cgs_flags);
        link_monitor_pkg::FRAME_SYNC_ADDR: state_d.rdata = 8'(state_q.frame_flags);
        link_monitor_pkg::CHECKSUM_GOOD_ADDR: state_d.rdata = 8'(state_q.checksum_flags);
        link_monitor_pkg::LANE_ALIGN_ADDR: state_d.rdata = 8'(state_q.align_flags);
        link_monitor_pkg::LINK_CTRL_ADDR: begin
          state_d.rdata[link_monitor_pkg::MASK_EN_BIT] = state_q.mask_enable;
          state_d.rdata[link_monitor_pkg::ILAS_TEST_BIT] = state_q.ilas_test;
        end
        // Enabled bits show event status, others show zero
        link_monitor_pkg::IRQ_ENABLE_ADDR: state_d.rdata = event_status & state_q.irq_enable;
        link_monitor_pkg::RESYNC_MASK_ADDR: begin
          state_d.rdata[link_monitor_pkg::RESYNC_MASK_LSB +: 3] = state_q.resync_mask;
          state_d.rdata[link_monitor_pkg::MISMATCH_ST_BIT] = state_q.mismatch_status;
          state_d.rdata[link_monitor_pkg::MISMATCH_EN_BIT] = state_q.mismatch_enable;
        end
        link_monitor_pkg::THRESHOLD_ADDR: state_d.rdata = state_q.threshold;
        default: begin
          if (a >= link_monitor_pkg::CFG_PARAM_BASE && a < link_monitor_pkg::CFG_PARAM_BASE + 12'(NB)) begin
            state_d.rdata = state_q.cfg_params[a - link_monitor_pkg::CFG_PARAM_BASE];
          end
          if (a >= link_monitor_pkg::RX_PARAM_BASE && a < link_monitor_pkg::RX_PARAM_BASE + 12'(NB)) begin
            state_d.rdata = rx_params_i[(a - link_monitor_pkg::RX_PARAM_BASE) * 8 +: 8];
          end
          if (a >= link_monitor_pkg::ERR_CTRL_BASE && a < link_monitor_pkg::ERR_CTRL_BASE + 12'(NT)) begin
            // Readback is the over-threshold state, not the written value
            state_d.rdata = 8'(reached[a - link_monitor_pkg::ERR_CTRL_BASE]);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= '0;
      state_q.mismatch_enable <= link_monitor_pkg::MISMATCH_EN_RESET;
      state_q.threshold <= link_monitor_pkg::THRESHOLD_RESET;
      state_q.sync_n <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata_o = state_q.rdata;
  assign sync_request_output_n_o = state_q.sync_n;
  assign irq_o = state_q.irq;
endmodule
`default_nettype wire

// [verification/link_port_monitor.sv]
// Port checker for the serial link error and status monitor
`default_nettype none
module link_port_monitor #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_rdata_o,
  // Link side
  input wire logic [LANES-1:0] disparity_error_i,
  input wire logic [LANES-1:0] code_group_sync_i,
  input wire logic [LANES-1:0] lane_alignment_i,
  input wire logic sync_request_output_n_o,
  input wire logic irq_o
);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [7:0] en_q;
  logic [7:0] frame_q;
  logic mm_en_q;
  logic mask_wr_q;
  logic [2:0] disp_q;
  logic [15:0] low_q;
  int hold_len;
  assign hold_len = 5 * (int'(frame_q) + 1) + 9;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q <= 8'h00;
      frame_q <= 8'h00;
      mm_en_q <= 1'b1;
      mask_wr_q <= 1'b0;
      disp_q <= 3'h0;
      low_q <= 16'h0000;
    end else begin
      if (reg_write_i && reg_addr_i == 12'h47A) en_q <= reg_wdata_i & 8'hEF;
      if (reg_write_i && reg_addr_i == 12'h454) frame_q <= reg_wdata_i;
      if (reg_write_i && reg_addr_i == 12'h47B) mm_en_q <= reg_wdata_i[3];
      if (reg_write_i && reg_addr_i == 12'h47B) mask_wr_q <= 1'b1;
      // Lane 0 only; the hold clears the design's counts too
      disp_q <= !sync_request_output_n_o ? 3'h0 : disp_q + 3'(disparity_error_i[0]);
      low_q <= sync_request_output_n_o ? 16'h0000 : low_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_disp_reinit;
    sync_request_output_n_o && disp_q == 3'h3 && disparity_error_i[0] |-> ##[1:3] !sync_request_output_n_o;
  endproperty
  a_disp_reinit: assert property (p_disp_reinit) else $error("no resync after disparity errors");
  property p_hold;
    $rose(sync_request_output_n_o) |-> low_q == 16'(hold_len);
  endproperty
  a_hold: assert property (p_hold) else $error("resync hold length wrong");
  property p_irq_enable;
    irq_o |-> (en_q | $past(en_q) | $past(en_q, 2)) != 8'h00 || mm_en_q || $past(mm_en_q) || $past(mm_en_q, 2);
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("interrupt with nothing enabled");
  property p_sticky;
    $fell(irq_o) |-> $past(reg_write_i) || $past(reg_write_i, 2) || $past(reg_write_i, 3);
  endproperty
  a_sticky: assert property (p_sticky) else $error("interrupt dropped without a write");
  property p_irq_read;
    reg_read_i && reg_addr_i == 12'h47A && !reg_write_i |=> (reg_rdata_o & ~en_q) == 8'h00;
  endproperty
  a_irq_read: assert property (p_irq_read) else $error("status shows a disabled event");
  property p_mm_reset;
    reg_read_i && reg_addr_i == 12'h47B && !mask_wr_q |=> reg_rdata_o[3];
  endproperty
  a_mm_reset: assert property (p_mm_reset) else $error("mismatch enable not set after reset");
  property p_cgs_read;
    reg_read_i && reg_addr_i == 12'h470 |=> reg_rdata_o[LANES-1:0] == $past(code_group_sync_i, 2);
  endproperty
  a_cgs_read: assert property (p_cgs_read) else $error("code group flags wrong");
  property p_ila_read;
    reg_read_i && reg_addr_i == 12'h473 |=> reg_rdata_o[LANES-1:0] == $past(lane_alignment_i, 2);
  endproperty
  a_ila_read: assert property (p_ila_read) else $error("lane alignment flags wrong");
endmodule
bind serial_link_error_status_monitor link_port_monitor #(.LANES(LANES)) mon_u (
  .clock_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
  .disparity_error_i, .code_group_sync_i, .lane_alignment_i, .sync_request_output_n_o, .irq_o);
`default_nettype wire

// [verification/link_tx_model.sv]
// Transmitter stand-in: lane error strobes, stage levels and lane parameters
`default_nettype none
module link_tx_model #(
  parameter int LANES = 4
) (
  // Clock
  input wire logic clock_i,
  // Lane error strobes
  output logic [LANES-1:0] dis_o,
  output logic [LANES-1:0] nit_o,
  output logic [LANES-1:0] ucc_o,
  // Link stage levels
  output logic [LANES-1:0] cgs_o,
  output logic [LANES-1:0] fs_o,
  output logic [LANES-1:0] ila_o,
  // Lane parameters
  output logic pv_o,
  output logic [link_monitor_pkg::PARAM_BYTES*8-1:0] par_o,
  output logic [LANES*8-1:0] sum_o,
  output logic [LANES*5-1:0] lid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  initial begin
    {dis_o, nit_o, ucc_o, pv_o, par_o, sum_o} = '0;
    {cgs_o, fs_o, ila_o} = '1;
    for (int l = 0; l < LANES; l++) lid_o[l*5+:5] = 5'(l);
  end
  // A quiet cycle between pulses keeps each strobe one character
  task automatic errors(input int kind, input int lane, input int n);
    repeat (n) begin
      @(negedge clock_i);
      {ucc_o[lane], nit_o[lane], dis_o[lane]} = 3'(1 << kind);
      @(negedge clock_i);
      {ucc_o, nit_o, dis_o} = '0;
    end
  endtask
  task automatic stage(input int which, input logic [LANES-1:0] v);
    @(negedge clock_i);
    case (which)
      0: cgs_o = v;
      1: fs_o = v;
      default: ila_o = v;
    endcase
    repeat (3) @(negedge clock_i);
  endtask
  // Byte 11 is in the packed sum only, so the two modes disagree
  task automatic ilas(input logic [7:0] spare, input logic [7:0] add);
    @(negedge clock_i);
    par_o[95:88] = spare;
    for (int l = 0; l < LANES; l++) sum_o[l*8+:8] = 8'(l) + add;
    pv_o = 1'b1;
    @(negedge clock_i);
    pv_o = 1'b0;
    repeat (3) @(negedge clock_i);
  endtask
endmodule
`default_nettype wire

// [verification/serial_link_error_status_monitor_tb.sv]
// Self-checking bench for the serial link error and status monitor
`default_nettype none
module serial_link_error_status_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LANES = 4;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [LANES-1:0] dis, nit, ucc, cgs, fs, ila;
  logic pv, sync_n, irq;
  logic [link_monitor_pkg::PARAM_BYTES*8-1:0] par;
  logic [LANES*8-1:0] sum;
  logic [LANES*5-1:0] lid;
  int failures = 0;
  int check_count = 0;
  int low_cycles = 0;
  always #4 clock_i = ~clock_i;
  always @(negedge clock_i) if (sync_n === 1'b0) low_cycles++;
  link_tx_model #(.LANES(LANES)) tx (.clock_i, .dis_o(dis), .nit_o(nit), .ucc_o(ucc), .cgs_o(cgs), .fs_o(fs),
    .ila_o(ila), .pv_o(pv), .par_o(par), .sum_o(sum), .lid_o(lid));
  serial_link_error_status_monitor #(.LANES(LANES), .COUNT_WIDTH(8)) dut (.clock_i, .reset_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o, .disparity_error_i(dis), .not_in_table_error_i(nit),
    .unexpected_control_error_i(ucc), .code_group_sync_i(cgs), .frame_sync_i(fs), .lane_alignment_i(ila),
    .params_valid_i(pv), .rx_params_i(par), .rx_checksum_i(sum), .rx_lane_id_i(lid),
    .sync_request_output_n_o(sync_n), .irq_o(irq));
  // ----------------------------------------------------------------
  // Register access and comparison
  // ----------------------------------------------------------------
  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_write_i = 1'b1;
    @(negedge clock_i);
    reg_write_i = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
    @(negedge clock_i);
    reg_addr_i = a;
    reg_read_i = 1'b1;
    @(negedge clock_i);
    reg_read_i = 1'b0;
    chk_val(name, {8'h00, exp}, {8'h00, reg_rdata_o});
  endtask
  task automatic t_reset();
    rd(12'h47B, 8'h08, "resync_mask_reset");
    rd(12'h47C, 8'hFF, "threshold_reset");
    rd(12'h47A, 8'h00, "irq_enable_reset");
    rd(12'h5AA, 8'h00, "unmapped_read");
    chk_val("sync_idle", 16'h0001, {15'h0000, sync_n});
  endtask
  task automatic t_disparity();
    low_cycles = 0;
    tx.errors(0, 0, 4);
    repeat (40) @(negedge clock_i);
    chk_val("disparity_hold", 16'h000E, 16'(low_cycles));
    wr(12'h46B, 8'h00);
    rd(12'h46B, 8'h00, "count_after_reinit");
  endtask
  task automatic t_threshold();
    wr(12'h47C, 8'h03);
    tx.errors(1, 1, 5);
    wr(12'h46B, 8'h11);
    rd(12'h46B, 8'h03, "nit_count_saturated");
    chk_val("sync_unmasked", 16'h0001, {15'h0000, sync_n});
    rd(12'h46E, 8'h02, "nit_reached_lanes");
    wr(12'h47A, 8'h60);
    rd(12'h47A, 8'h40, "nit_irq_status");
    chk_val("irq_set", 16'h0001, {15'h0000, irq});
    wr(12'h46E, 8'h21);
    wr(12'h46E, 8'h81);
    rd(12'h47A, 8'h00, "nit_irq_cleared");
    wr(12'h46F, 8'h40);
    tx.errors(2, 0, 1);
    wr(12'h46B, 8'h02);
    rd(12'h46B, 8'h00, "ucc_count_disabled");
    wr(12'h46F, 8'h20);
    wr(12'h477, 8'h08);
    for (int k = 1; k < 3; k++) begin
      wr(12'h47B, 8'h80 >> k);
      low_cycles = 0;
      tx.errors(k, 2, 3);
      repeat (40) @(negedge clock_i);
      chk_val("masked_hold", 16'h000E, 16'(low_cycles));
    end
    wr(12'h46B, 8'h21);
    rd(12'h46B, 8'h00, "count_after_reinit");
    rd(12'h47A, 8'h60, "irq_kept_after_reinit");
    wr(12'h46E, 8'h82);
    wr(12'h46F, 8'h82);
    wr(12'h47B, 8'h08);
  endtask
  task automatic t_stages();
    int b;
    wr(12'h47A, 8'h0F);
    rd(12'h470, 8'h0F, "cgs_flags");
    rd(12'h471, 8'h0F, "frame_flags");
    rd(12'h473, 8'h0F, "align_flags");
    for (int i = 0; i < 3; i++) begin
      b = (i == 2) ? 3 : i;
      tx.stage(i, 4'hE);
      rd(12'h47A, 8'(1 << b), "stage_fail_irq");
      chk_val("irq_stage", 16'h0001, {15'h0000, irq});
      tx.stage(i, 4'hF);
      wr(12'h470 + 12'(b), 8'h80);
      rd(12'h47A, 8'h00, "stage_irq_cleared");
    end
  endtask
  task automatic t_checksum();
    tx.ilas(8'h05, 8'h00);
    rd(12'h472, 8'h0F, "checksum_fields");
    rd(12'h47B, 8'h18, "mismatch_status");
    wr(12'h300, 8'h40);
    tx.ilas(8'h05, 8'h00);
    rd(12'h472, 8'h00, "checksum_packed_bad");
    rd(12'h47A, 8'h04, "checksum_fail_irq");
    tx.ilas(8'h05, 8'h05);
    rd(12'h472, 8'h0F, "checksum_packed_good");
    wr(12'h472, 8'h80);
    wr(12'h45B, 8'h05);
    rd(12'h40B, 8'h05, "rx_param_byte");
    rd(12'h45B, 8'h05, "cfg_param_byte");
    wr(12'h47B, 8'h18);
    rd(12'h47B, 8'h08, "mismatch_cleared");
    repeat (2) @(negedge clock_i);
    chk_val("irq_all_clear", 16'h0000, {15'h0000, irq});
  endtask
  task automatic give_verdict();
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (12) @(negedge clock_i);
    reset_n_i = 1'b1;
    t_reset();
    t_disparity();
    t_threshold();
    t_stages();
    t_checksum();
    give_verdict();
  end
endmodule
`default_nettype wire
